// File: dv/sqcfg_host.sv
`timescale 1ns/10ps
module sqcfg_host (
    // clock
    input wire logic sys_clk,
    // register port
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn,
    input wire logic [7:0] regRdData
);
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    // strobe is taken at the next edge; data stands for the cycle after it
    task automatic readReg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge sys_clk);
        #1;
        d = regRdData;
        regRdEn = 1'b0;
        regAddr = ~a;
    endtask : readReg
    task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge sys_clk);
        #1;
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask : writeReg
endmodule : sqcfg_host

// File: dv/sqcfg_regs_bench.sv
`timescale 1ns/10ps
`include "sqcfg_regs_cfg.svh"
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin badCount++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module sqcfg_regs_bench;
    logic sys_clk, rst_b, regWrEn, regRdEn, selftestDoneStb, eccCorrStb;
    logic faultFlagClear, nvmLoadStb, crystalLoadInternal, crystalDriverOn;
    logic slowclkPushpull;
    logic [7:0] regAddr, regWrData, regRdData, rd, cause, st;
    logic [7:0] nv [5];
    logic [7:0] msk [5] = '{`SQCFG_MSK_LOW4, `SQCFG_MSK_SEL, `SQCFG_MSK_LOW4,
        8'hff, `SQCFG_MSK_OSC};
    logic [3:0] selftestFail, seqFieldsUsed, altActive, altSelect;
    logic [2:0] causeEvent, ev;
    logic [1:0] causeCode, cd;
    logic [11:0] pinPushpullSelect;
    int badCount, checksDone;
    sqcfg_regs u_dut (.sys_clk, .rst_b, .regAddr, .regWrEn, .regWrData,
        .regRdEn, .regRdData, .selftestDoneStb, .selftestFail, .eccCorrStb,
        .faultFlagClear, .causeEvent, .causeCode, .nvmLoadStb,
        .nvmAltEnable(nv[0]), .nvmAltSelect(nv[1]), .nvmDrvUpper(nv[2]),
        .nvmDrvLower(nv[3]), .nvmOsc(nv[4]), .seqFieldsUsed, .altActive,
        .altSelect, .pinPushpullSelect, .crystalLoadInternal,
        .crystalDriverOn, .slowclkPushpull);
    sqcfg_host u_host (.sys_clk, .regAddr, .regWrEn, .regWrData, .regRdEn,
        .regRdData);
    function automatic logic [7:0] nextCause(input logic [7:0] c,
        input logic [2:0] e, input logic [1:0] k);
        case (e)
            3'd1: return 8'h80;
            3'd2: return 8'h40;
            3'd3: return 8'h10;
            3'd4: return 8'h08;
            3'd5: return {6'b000001, k};
            // a forced code of zero is no shutdown request at all
            3'd6: return (k != 2'b00) ? {6'b000000, k} : c;
            default: return c;
        endcase
    endfunction : nextCause
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic completeRun;
        $display("comparisons %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : completeRun
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        badCount++;
        completeRun;
    end
    initial begin
        {rst_b, selftestDoneStb, eccCorrStb, faultFlagClear, nvmLoadStb} = 0;
        {selftestFail, seqFieldsUsed, causeEvent, causeCode} = 0;
        foreach (nv[i]) nv[i] = 8'h00;
        void'($urandom(3));
        repeat (5) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        repeat (4) tick;
        u_host.readReg(`SQCFG_OFS_RSTCAUSE, rd);
        `CHK("cause at power on", `SQCFG_RST_CAUSE, rd)
        u_host.readReg(`SQCFG_OFS_SELFTEST, rd);
        `CHK("selftest at power on", `SQCFG_RST_SELFTEST, rd)
        $display("test power_on done");
        // second pass offers inverted bytes and writes: both must be ignored
        for (int p = 0; p < 2; p++) begin
            tick;
            foreach (nv[i]) nv[i] = (p == 0) ? 8'($urandom) : ~nv[i];
            nvmLoadStb = 1'b1;
            tick;
            nvmLoadStb = 1'b0;
            if (p == 1) foreach (nv[i]) nv[i] = ~nv[i];
            for (int i = 0; i < 5; i++) begin
                if (p == 1) u_host.writeReg(8'h20 + 8'(i), 8'($urandom));
                u_host.readReg(8'h20 + 8'(i), rd);
                `CHK("config byte", nv[i] & msk[i], rd)
            end
        end
        `CHK("select", nv[1][3:0] & 4'he, altSelect)
        `CHK("drive", {nv[2][3:0], nv[3]}, pinPushpullSelect)
        `CHK("crystal_load_internal", nv[4][7], crystalLoadInternal)
        `CHK("xtal on", nv[4][6], crystalDriverOn)
        `CHK("clk drive", nv[4][4], slowclkPushpull)
        $display("test config done");
        for (int k = 0; k < 6; k++) begin
            seqFieldsUsed = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'($urandom);
            repeat (5) tick;
            `CHK("alt active", nv[0][3:0] & ~seqFieldsUsed, altActive)
        end
        $display("test alt_lock done");
        u_host.writeReg(`SQCFG_OFS_SELFTEST, 8'hff);
        u_host.readReg(`SQCFG_OFS_SELFTEST, rd);
        `CHK("selftest before done", 8'h00, rd)
        selftestFail = 4'($urandom);
        selftestDoneStb = 1'b1;
        tick;
        selftestDoneStb = 1'b0;
        st = {4'b0100, selftestFail};
        selftestFail = ~selftestFail;
        u_host.readReg(`SQCFG_OFS_SELFTEST, rd);
        `CHK("selftest done", st, rd)
        eccCorrStb = 1'b1;
        tick;
        eccCorrStb = 1'b0;
        faultFlagClear = 1'b1;
        tick;
        faultFlagClear = 1'b0;
        u_host.readReg(`SQCFG_OFS_SELFTEST, rd);
        `CHK("selftest ecc", st | 8'h20, rd)
        $display("test selftest done");
        cause = 8'h00;
        for (int i = 0; i < 20; i++) begin
            ev = (i < 8) ? 3'(i) : 3'($urandom);
            cd = (i == 6) ? 2'b00 : 2'($urandom);
            causeEvent = ev;
            causeCode = cd;
            tick;
            causeEvent = 3'd0;
            causeCode = ~cd;
            cause = nextCause(cause, ev, cd);
            u_host.readReg(`SQCFG_OFS_RSTCAUSE, rd);
            `CHK("cause", cause, rd)
        end
        $display("test cause done");
        u_host.readReg(8'h30, rd);
        `CHK("unmapped", 8'h00, rd)
        u_host.readReg(8'h1b, rd);
        `CHK("unmapped", 8'h00, rd)
        $display("test unmapped done");
        completeRun;
    end
endmodule : sqcfg_regs_bench

// File: hdl/sqcfg_regs.sv
`timescale 1ns/10ps
`include "sqcfg_regs_cfg.svh"
module sqcfg_regs
    import sqcfg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port: byte address, write strobe, read data
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // self-test and ecc results, pulse on done
    input wire logic selftestDoneStb,
    input wire logic [3:0] selftestFail,
    input wire logic eccCorrStb,
    input wire logic faultFlagClear,
    // reset and shutdown cause events, one-cycle pulses
    input wire logic [2:0] causeEvent,
    input wire logic [1:0] causeCode,
    // nvm load of configuration, pulse with data
    input wire logic nvmLoadStb,
    input wire logic [7:0] nvmAltEnable,
    input wire logic [7:0] nvmAltSelect,
    input wire logic [7:0] nvmDrvUpper,
    input wire logic [7:0] nvmDrvLower,
    input wire logic [7:0] nvmOsc,
    // sequencing fields nonzero per pin 12..9
    input wire logic [3:0] seqFieldsUsed,
    // configuration outputs
    output logic [3:0] altActive,
    output logic [3:0] altSelect,
    output logic [11:0] pinPushpullSelect,
    output logic crystalLoadInternal,
    output logic crystalDriverOn,
    output logic slowclkPushpull
);
    typedef struct packed {
        logic [7:0] stat;
        logic [7:0] cause;
        logic [7:0] altEn;
        logic [7:0] altSel;
        logic [7:0] drvUp;
        logic [7:0] drvLo;
        logic [7:0] osc;
        sqcfg_phase_t phase;
        logic [7:0] rd;
        logic [3:0] altAct;
    } sqcfg_state_t;
    sqcfg_state_t st_q;
    sqcfg_state_t st_d;
    logic rstSyncB;
    logic [3:0] seqUsedSync;
    // the release pipe sits apart from the state struct: it runs on the
    // raw reset while everything else waits for the clean copy
    logic [1:0] rstPipe_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe_q <= 2'b00;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstSyncB = rstPipe_q[1];

    // sequencing fields come from another block's registers but may be
    // changed by an nvm path; synchronise to be safe
    sqcfg_sync2 #(.WIDTH(4)) seqSync (
        .sys_clk(sys_clk),
        .rstSyncB(rstSyncB),
        .asyncIn(seqFieldsUsed),
        .syncOut(seqUsedSync)
    );

    always_comb begin
        st_d = st_q;
        if (selftestDoneStb) begin
            st_d.stat[`SQCFG_BIT_DONE] = 1'b1; // R1
            st_d.stat[`SQCFG_BIT_VM] = selftestFail[3]; // R3
            st_d.stat[`SQCFG_BIT_NVM] = selftestFail[2];
            st_d.stat[`SQCFG_BIT_LOGIC] = selftestFail[1];
            st_d.stat[`SQCFG_BIT_ANALOG] = selftestFail[0];
        end
        // fault flag clear has no path into the status bits
        if (faultFlagClear) begin
            st_d.stat = st_d.stat; // R23
        end
        if (eccCorrStb) begin
            st_d.stat[`SQCFG_BIT_SEC] = 1'b1; // R2
        end
        st_d.stat[7] = 1'b0;
        st_d.stat[4] = 1'b0;
        // every event except code 7 and a forced code of zero overwrites the whole cause byte
        unique case (causeEvent)
            SQCFG_EV_EXTRST: begin
                st_d.cause = `SQCFG_RST_CAUSE; // R6
                st_d.cause[`SQCFG_BIT_EXTRST] = 1'b1; // R9
            end
            SQCFG_EV_WDRST: begin
                st_d.cause = `SQCFG_RST_CAUSE;
                st_d.cause[`SQCFG_BIT_WDRST] = 1'b1; // R10
            end
            SQCFG_EV_EMPD: begin
                st_d.cause = `SQCFG_RST_CAUSE;
                st_d.cause[`SQCFG_BIT_EMPD] = 1'b1; // R11
            end
            SQCFG_EV_ACTLOW: begin
                st_d.cause = `SQCFG_RST_CAUSE;
                st_d.cause[`SQCFG_BIT_ACTLOW] = 1'b1; // R12
            end
            SQCFG_EV_WDSHDN: begin
                // the powerdown mode rides in the forced-code field
                st_d.cause = {6'h00, causeCode}; // R13
                st_d.cause[`SQCFG_BIT_WDSHDN] = 1'b1;
            end
            SQCFG_EV_FORCE: begin
                if (causeCode != 2'b00) begin
                    st_d.cause = {6'h00, causeCode}; // R14
                end
            end
            // emergency sequence 2 is logged elsewhere
            default: st_d.cause = st_q.cause; // R7
        endcase
        unique case (st_q.phase)
            SQCFG_IDLE: begin
                if (nvmLoadStb) begin
                    st_d.phase = SQCFG_LOAD;
                end
            end
            SQCFG_LOAD: begin
                st_d.phase = SQCFG_LOCKED;
            end
            SQCFG_LOCKED: begin
                st_d.phase = SQCFG_LOCKED;
            end
            default: st_d.phase = SQCFG_IDLE;
        endcase
        if (st_q.phase == SQCFG_IDLE && nvmLoadStb) begin
            st_d.altEn = nvmAltEnable & `SQCFG_MSK_LOW4; // R19 R15
            st_d.altSel = nvmAltSelect & `SQCFG_MSK_SEL; // R17 R18
            st_d.drvUp = nvmDrvUpper & `SQCFG_MSK_LOW4; // R20
            st_d.drvLo = nvmDrvLower;
            st_d.osc = nvmOsc & `SQCFG_MSK_OSC; // R21 R22
        end
        st_d.altAct = st_q.altEn[3:0] & ~seqUsedSync; // R16
        st_d.rd = 8'h00;
        if (regRdEn) begin
            unique case (regAddr)
                `SQCFG_OFS_SELFTEST: st_d.rd = st_q.stat; // R4
                `SQCFG_OFS_RSTCAUSE: st_d.rd = st_q.cause;
                `SQCFG_OFS_ALTEN: st_d.rd = st_q.altEn;
                `SQCFG_OFS_ALTSEL: st_d.rd = st_q.altSel;
                `SQCFG_OFS_DRVUP: st_d.rd = st_q.drvUp;
                `SQCFG_OFS_DRVLO: st_d.rd = st_q.drvLo;
                `SQCFG_OFS_OSC: st_d.rd = st_q.osc;
                default: st_d.rd = 8'h00; // R24
            endcase
        end
        // all registers here are read-only, writes are dropped
        if (regWrEn) begin
            st_d.stat = st_d.stat; // R24
        end
    end

    // cause shares the synchronised reset with the rest of the state and clears on it
    always_ff @(posedge sys_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            st_q.stat <= `SQCFG_RST_SELFTEST;
            st_q.cause <= `SQCFG_RST_CAUSE; // R5
            st_q.altEn <= `SQCFG_RST_CFG;
            st_q.altSel <= `SQCFG_RST_CFG;
            st_q.drvUp <= `SQCFG_RST_CFG;
            st_q.drvLo <= `SQCFG_RST_CFG;
            st_q.osc <= `SQCFG_RST_CFG;
            st_q.phase <= SQCFG_IDLE;
            st_q.rd <= 8'h00;
            st_q.altAct <= 4'h0;
        end else begin
            st_q.stat <= st_d.stat;
            st_q.cause <= st_d.cause;
            st_q.altEn <= st_d.altEn;
            st_q.altSel <= st_d.altSel;
            st_q.drvUp <= st_d.drvUp;
            st_q.drvLo <= st_d.drvLo;
            st_q.osc <= st_d.osc;
            st_q.phase <= st_d.phase;
            st_q.rd <= st_d.rd;
            st_q.altAct <= st_d.altAct;
        end
    end

    assign regRdData = st_q.rd;
    assign altActive = st_q.altAct;
    assign altSelect = st_q.altSel[3:0];
    assign pinPushpullSelect = {st_q.drvUp[3:0], st_q.drvLo};
    assign crystalLoadInternal = st_q.osc[7];
    assign crystalDriverOn = st_q.osc[6];
    assign slowclkPushpull = st_q.osc[4];

    AST_DONE_STICKY: assert property (@(posedge sys_clk) // R1
        disable iff (!rstSyncB)
        $past(selftestDoneStb) |-> st_q.stat[`SQCFG_BIT_DONE])
        else $error("done bit not set after self-test");
    AST_SEC_SET: assert property (@(posedge sys_clk) // R2
        disable iff (!rstSyncB)
        eccCorrStb |=> st_q.stat[`SQCFG_BIT_SEC])
        else $error("correction bit not set");
    AST_FAIL_COPY: assert property (@(posedge sys_clk) // R3
        disable iff (!rstSyncB)
        selftestDoneStb |=> st_q.stat[3:0] == $past(selftestFail))
        else $error("fail bits wrong");
    AST_STAT_RSVD: assert property (@(posedge sys_clk) // R4
        disable iff (!rstSyncB)
        st_q.stat[7] == 1'b0 && st_q.stat[4] == 1'b0)
        else $error("reserved status bits set");
    AST_EXTRST: assert property (@(posedge sys_clk) // R9
        disable iff (!rstSyncB)
        causeEvent == SQCFG_EV_EXTRST |=> st_q.cause == 8'h80)
        else $error("external reset cause wrong");
    AST_WDRST: assert property (@(posedge sys_clk) // R10
        disable iff (!rstSyncB)
        causeEvent == SQCFG_EV_WDRST |=> st_q.cause == 8'h40)
        else $error("watchdog reset cause wrong");
    AST_WDSHDN: assert property (@(posedge sys_clk) // R13
        disable iff (!rstSyncB)
        causeEvent == SQCFG_EV_WDSHDN |=>
            st_q.cause == {6'h01, $past(causeCode)})
        else $error("watchdog shutdown cause wrong");
    AST_FORCE: assert property (@(posedge sys_clk) // R14
        disable iff (!rstSyncB)
        causeEvent == SQCFG_EV_FORCE && causeCode != 2'b00 |=>
            st_q.cause == {6'h00, $past(causeCode)})
        else $error("forced shutdown code wrong");
    AST_ALT_LOCK: assert property (@(posedge sys_clk) // R16
        disable iff (!rstSyncB)
        (altActive & seqUsedSync) == 4'h0 || $changed(seqUsedSync))
        else $error("alt function active on sequenced pin");
    AST_SEL9_ZERO: assert property (@(posedge sys_clk) // R18
        disable iff (!rstSyncB)
        st_q.altSel[0] == 1'b0)
        else $error("pin 9 select nonzero");
    AST_CFG_LOCK: assert property (@(posedge sys_clk) // R19
        disable iff (!rstSyncB)
        st_q.phase == SQCFG_LOCKED |=> $stable(st_q.osc)
            && $stable(st_q.altEn) && $stable(st_q.drvLo))
        else $error("config changed after lock");
    AST_UNMAPPED: assert property (@(posedge sys_clk) // R24
        disable iff (!rstSyncB)
        regRdEn && regAddr == 8'h1b |=> regRdData == 8'h00)
        else $error("unmapped read nonzero");

    // steps of the one-time load, of a register read and of a cycle with no cause event
    sequence sqLoadTaken;
        st_q.phase == SQCFG_IDLE && nvmLoadStb;
    endsequence
    sequence sqLoadSettle;
        st_q.phase == SQCFG_LOAD ##1 st_q.phase == SQCFG_LOCKED;
    endsequence
    sequence sqStatRead;
        regRdEn && regAddr == `SQCFG_OFS_SELFTEST;
    endsequence
    sequence sqCauseRead;
        regRdEn && regAddr == `SQCFG_OFS_RSTCAUSE;
    endsequence
    sequence sqNoCause;
        causeEvent == SQCFG_EV_NONE || causeEvent == 3'h7
            || (causeEvent == SQCFG_EV_FORCE && causeCode == 2'h0);
    endsequence
    AST_LOAD_STEPS: assert property (@(posedge sys_clk) // R19
        disable iff (!rstSyncB)
        sqLoadTaken |=> sqLoadSettle)
        else $error("load did not lock the configuration");
    AST_LOCK_HOLD: assert property (@(posedge sys_clk) // R19
        disable iff (!rstSyncB)
        st_q.phase == SQCFG_LOCKED |=> st_q.phase == SQCFG_LOCKED)
        else $error("configuration lock released");
    AST_LOAD_ALTEN: assert property (@(posedge sys_clk) // R15
        disable iff (!rstSyncB)
        sqLoadTaken |=>
            st_q.altEn == ($past(nvmAltEnable) & `SQCFG_MSK_LOW4))
        else $error("alt enable not loaded");
    AST_LOAD_ALTSEL: assert property (@(posedge sys_clk) // R17
        disable iff (!rstSyncB)
        sqLoadTaken |=>
            st_q.altSel == ($past(nvmAltSelect) & `SQCFG_MSK_SEL))
        else $error("alt select not loaded");
    AST_LOAD_DRIVE: assert property (@(posedge sys_clk) // R20
        disable iff (!rstSyncB)
        sqLoadTaken |=> st_q.drvLo == $past(nvmDrvLower)
            && st_q.drvUp == ($past(nvmDrvUpper) & `SQCFG_MSK_LOW4))
        else $error("drive modes not loaded");
    AST_LOAD_OSC: assert property (@(posedge sys_clk) // R21
        disable iff (!rstSyncB)
        sqLoadTaken |=> st_q.osc == ($past(nvmOsc) & `SQCFG_MSK_OSC))
        else $error("oscillator config not loaded");
    AST_CFG_RSVD: assert property (@(posedge sys_clk) // R24
        disable iff (!rstSyncB)
        st_q.altEn[7:4] == 4'h0 && st_q.altSel[7:4] == 4'h0
            && st_q.drvUp[7:4] == 4'h0 && st_q.osc[5] == 1'b0
            && st_q.osc[3:0] == 4'h0)
        else $error("reserved config bits set");
    AST_RD_STAT: assert property (@(posedge sys_clk) // R4
        disable iff (!rstSyncB)
        sqStatRead |=> regRdData == $past(st_q.stat))
        else $error("status read data wrong");
    AST_RD_CAUSE: assert property (@(posedge sys_clk) // R6
        disable iff (!rstSyncB)
        sqCauseRead |=> regRdData == $past(st_q.cause))
        else $error("cause read data wrong");
    AST_RD_IDLE: assert property (@(posedge sys_clk) // R24
        disable iff (!rstSyncB)
        !regRdEn |=> regRdData == 8'h00)
        else $error("read data stands without a read");
    AST_CAUSE_HOLD: assert property (@(posedge sys_clk) // R5
        disable iff (!rstSyncB)
        sqNoCause |=> $stable(st_q.cause))
        else $error("cause changed without an event");
    AST_EMPD: assert property (@(posedge sys_clk) // R11
        disable iff (!rstSyncB)
        causeEvent == SQCFG_EV_EMPD |=> st_q.cause == 8'h10)
        else $error("emergency powerdown cause wrong");
    AST_ACTLOW: assert property (@(posedge sys_clk) // R12
        disable iff (!rstSyncB)
        causeEvent == SQCFG_EV_ACTLOW |=> st_q.cause == 8'h08)
        else $error("active low cause wrong");
    AST_DONE_HOLD: assert property (@(posedge sys_clk) // R1
        disable iff (!rstSyncB)
        !selftestDoneStb && !st_q.stat[`SQCFG_BIT_DONE] |=>
            !st_q.stat[`SQCFG_BIT_DONE])
        else $error("done bit set without self-test");
    AST_SEC_CLEAN: assert property (@(posedge sys_clk) // R2
        disable iff (!rstSyncB)
        !eccCorrStb && !st_q.stat[`SQCFG_BIT_SEC] |=>
            !st_q.stat[`SQCFG_BIT_SEC])
        else $error("correction bit set without correction");
    AST_CLEAR_KEEPS: assert property (@(posedge sys_clk) // R23
        disable iff (!rstSyncB)
        faultFlagClear && !selftestDoneStb && !eccCorrStb |=>
            $stable(st_q.stat))
        else $error("fault clear touched self-test results");
    AST_ALT_FOLLOW: assert property (@(posedge sys_clk) // R16
        disable iff (!rstSyncB)
        altActive == ($past(st_q.altEn[3:0]) & ~$past(seqUsedSync)))
        else $error("alt active does not follow enable and lock");
endmodule : sqcfg_regs

// File: hdl/sqcfg_sync2.sv
`timescale 1ns/10ps
module sqcfg_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstSyncB,
    // data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] out;
    } sqcfg_sync_t;
    sqcfg_sync_t st_q;
    sqcfg_sync_t st_d;
    always_comb begin
        st_d.meta = asyncIn;
        st_d.out = st_q.meta;
    end
    always_ff @(posedge sys_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign syncOut = st_q.out;
endmodule : sqcfg_sync2

// File: include/sqcfg_pkg.sv
package sqcfg_pkg;
    typedef enum logic [1:0] {
        SQCFG_IDLE = 2'b00,
        SQCFG_LOAD = 2'b01,
        SQCFG_LOCKED = 2'b11
    } sqcfg_phase_t;
    typedef enum logic [2:0] {
        SQCFG_EV_NONE = 3'd0,
        SQCFG_EV_EXTRST = 3'd1,
        SQCFG_EV_WDRST = 3'd2,
        SQCFG_EV_EMPD = 3'd3,
        SQCFG_EV_ACTLOW = 3'd4,
        SQCFG_EV_WDSHDN = 3'd5,
        SQCFG_EV_FORCE = 3'd6
    } sqcfg_cause_t;
endpackage : sqcfg_pkg

// File: include/sqcfg_regs_cfg.svh
// Overview of operation
// [R1] bit 6 flags self-test completed
// [R2] bit 5 flags single-error correction on load
// [R3] fail bits: vm 3, nvm 2, logic 1, analog 0
// [R4] self-test status at 0x19, read-only, reset 0x00
// [R5] reset cause kept while any supply present; here it clears to 0x00 on every rst_b reset
// [R6] each new reset or shutdown overwrites cause
// [R7] emergency shutdown sequence need not be recorded
// [R8] host reads reset cause early after power-on
// [R9] bit 7 set for external reset input
// [R10] bit 6 set for watchdog reset
// [R11] bit 4 set for emergency powerdown input
// [R12] bit 3 set for active input low
// [R13] watchdog shutdown sets bit 2, copies mode
// [R14] forced shutdown code stored in bits 1:0
// [R15] alt enable bits: pin12 bit3 .. pin9 bit0
// [R16] alt function only with zero sequencing fields
// [R17] select bits pick output or input function
// [R18] pin9 select bit always reads zero
// [R19] config loaded from nvm, then read-only
// [R20] drive bit 0 open-drain, 1 push-pull
// [R21] bit 7 internal load, bit 6 crystal on
// [R22] bit 4 selects slow clock push-pull
// [R23] clearing fault flag keeps self-test results
// [R24] read-only writes ignored, reserved read zero
`ifndef SQCFG_REGS_CFG_SVH
`define SQCFG_REGS_CFG_SVH
`define SQCFG_OFS_SELFTEST 8'h19
`define SQCFG_OFS_RSTCAUSE 8'h1a
`define SQCFG_OFS_ALTEN 8'h20
`define SQCFG_OFS_ALTSEL 8'h21
`define SQCFG_OFS_DRVUP 8'h22
`define SQCFG_OFS_DRVLO 8'h23
`define SQCFG_OFS_OSC 8'h24
`define SQCFG_RST_SELFTEST 8'h00
`define SQCFG_RST_CAUSE 8'h00
`define SQCFG_RST_CFG 8'h00
`define SQCFG_BIT_DONE 6
`define SQCFG_BIT_SEC 5
`define SQCFG_BIT_VM 3
`define SQCFG_BIT_NVM 2
`define SQCFG_BIT_LOGIC 1
`define SQCFG_BIT_ANALOG 0
`define SQCFG_BIT_EXTRST 7
`define SQCFG_BIT_WDRST 6
`define SQCFG_BIT_EMPD 4
`define SQCFG_BIT_ACTLOW 3
`define SQCFG_BIT_WDSHDN 2
`define SQCFG_MSK_LOW4 8'h0f
`define SQCFG_MSK_SEL 8'h0e
`define SQCFG_MSK_OSC 8'hd0
`endif
